/* pmon_top.sv */
// Purpose: measurement control and result registers of the power monitor
// Assumes: register port is the internal side of the serial interface
// Notes:   adc codes are sampled at the end of each conversion time
`timescale 1ns/1ns
`default_nettype none
`include "pmon_defines.svh"
module pmon_top #(
    parameter int unsigned CT_CYC [8] = '{
        `PMON_CT0_NS / `PMON_CLK_NS, `PMON_CT1_NS / `PMON_CLK_NS,
        `PMON_CT2_NS / `PMON_CLK_NS, `PMON_CT3_NS / `PMON_CLK_NS,
        `PMON_CT4_NS / `PMON_CLK_NS, `PMON_CT5_NS / `PMON_CLK_NS,
        `PMON_CT6_NS / `PMON_CLK_NS, `PMON_CT7_NS / `PMON_CLK_NS}
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // converter codes
    input  wire logic [15:0] shunt_code,
    input  wire logic [15:0] bus_code,
    // status
    input  wire logic        flag_clr,
    output logic             conversion_done_flag,
    output logic             math_ovf,
    output logic             conv_busy
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    pmon_pkg::pmon_state_e state_r, state_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [15:0] cal_r, cal_nxt;
    logic [15:0] shunt_r, shunt_nxt;
    logic [15:0] bus_r, bus_nxt;
    logic [15:0] cur_r, cur_nxt;
    logic [15:0] pwr_r, pwr_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [10:0] scnt_r, scnt_nxt;
    logic        flag_r, flag_nxt;
    logic        ovf_r, ovf_nxt;
    logic        busy_r, busy_nxt;
    logic        srst_r, srst_nxt;
    logic        trig_r, trig_nxt;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic        cfg_wr;
    logic        do_sh;
    logic        do_bus;
    logic        cont;
    logic        pdown;
    logic [2:0]  mode;
    logic [3:0]  log2n;
    logic [10:0] ncnt;
    logic        tmr_start;
    logic        tmr_done;
    logic        acc_clr;
    logic        add_sh;
    logic        add_bus;
    logic [2:0]  tmr_code;
    logic [15:0] avg_sh;
    logic [15:0] avg_bus;
    logic [15:0] bus_pos;

    assign cfg_wr = reg_wr && reg_addr == `PMON_OFS_CFG;
    assign mode   = cfg_r[`PMON_CFG_MODE +: 3];
    assign do_sh  = mode[0];
    assign do_bus = mode[1];
    assign cont   = mode[2];
    assign pdown  = !do_sh && !do_bus;
    assign bus_pos = {1'b0, bus_code[14:0]};

    always_comb begin
        case (cfg_r[`PMON_CFG_AVG +: 3])
            3'h0:    log2n = 4'h0;
            3'h1:    log2n = 4'h2;
            3'h2:    log2n = 4'h4;
            3'h3:    log2n = 4'h6;
            3'h4:    log2n = 4'h7;
            3'h5:    log2n = 4'h8;
            3'h6:    log2n = 4'h9;
            default: log2n = 4'ha;
        endcase
    end
    assign ncnt = 11'h001 << log2n;

    // ----------------------------------------
    // result arithmetic
    // ----------------------------------------
    logic        [15:0] sh_v;
    logic        [15:0] bus_v;
    logic signed [31:0] prod_c;
    logic signed [31:0] curw_c;
    logic        [15:0] cur_c;
    logic        [15:0] mag_c;
    logic        [31:0] pw_c;
    logic               sat_c;

    assign sh_v  = do_sh ? avg_sh : shunt_r;
    assign bus_v = do_bus ? avg_bus : bus_r;
    assign prod_c = $signed({{16{sh_v[15]}}, sh_v})
                    * $signed({17'h00000, cal_r[14:0]});
    assign curw_c = prod_c >>> `PMON_CUR_SHIFT;

    always_comb begin
        sat_c = 1'b1;
        if (curw_c > 32'sd32767) begin
            cur_c = 16'h7fff;
        end else if (curw_c < -32'sd32768) begin
            cur_c = 16'h8000;
        end else begin
            cur_c = curw_c[15:0];
            sat_c = 1'b0;
        end
    end
    assign mag_c = cur_c[15] ? 16'(-cur_c) : cur_c;
    // divider folds the 25-step power unit and the 1.25 mV bus count
    assign pw_c = ({16'h0000, mag_c} * {16'h0000, bus_v})
                  / `PMON_PWR_DIV;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        scnt_nxt  = scnt_r;
        busy_nxt  = busy_r;
        trig_nxt  = trig_r;
        tmr_start = 1'b0;
        tmr_code  = cfg_r[`PMON_CFG_SCT +: 3];
        acc_clr   = 1'b0;
        add_sh    = 1'b0;
        add_bus   = 1'b0;
        if (cfg_wr) begin
            state_nxt = pmon_pkg::ST_IDLE;
            scnt_nxt  = '0;
            busy_nxt  = 1'b0;
            trig_nxt  = 1'b1;
            acc_clr   = 1'b1;
        end else begin
            case (state_r)
                pmon_pkg::ST_IDLE: begin
                    if (!pdown && (cont || trig_r)) begin
                        trig_nxt  = 1'b0;
                        busy_nxt  = 1'b1;
                        acc_clr   = 1'b1;
                        scnt_nxt  = '0;
                        tmr_start = 1'b1;
                        state_nxt = do_sh ? pmon_pkg::ST_SHUNT
                                          : pmon_pkg::ST_BUS;
                    end else begin
                        trig_nxt = trig_r && !pdown;
                    end
                end
                pmon_pkg::ST_SHUNT: begin
                    if (tmr_done) begin
                        add_sh = 1'b1;
                        if (do_bus) begin
                            tmr_start = 1'b1;
                            state_nxt = pmon_pkg::ST_BUS;
                        end else begin
                            scnt_nxt = scnt_r + 1'b1;
                        end
                    end
                end
                pmon_pkg::ST_BUS: begin
                    if (tmr_done) begin
                        add_bus  = 1'b1;
                        scnt_nxt = scnt_r + 1'b1;
                    end
                end
                pmon_pkg::ST_MATH: begin
                    busy_nxt  = 1'b0;
                    state_nxt = pmon_pkg::ST_IDLE;
                end
                default: begin
                    state_nxt = pmon_pkg::ST_IDLE;
                end
            endcase
            // one sample set done: next set or products
            if (add_bus || (add_sh && !do_bus)) begin
                if (scnt_nxt == ncnt) begin
                    state_nxt = pmon_pkg::ST_MATH;
                end else begin
                    tmr_start = 1'b1;
                    state_nxt = do_sh ? pmon_pkg::ST_SHUNT
                                      : pmon_pkg::ST_BUS;
                end
            end
        end
        if (state_nxt == pmon_pkg::ST_BUS) begin
            tmr_code = cfg_r[`PMON_CFG_BCT +: 3];
        end
    end

    pmon_conv_timer #(
        .CT_CYC (CT_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (tmr_start),
        .abort    (cfg_wr || srst_r),
        .code     (tmr_code),
        .done     (tmr_done)
    );

    pmon_avg #(
        .W  (16),
        .NW (10)
    ) u_avg_sh (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clr      (acc_clr),
        .add      (add_sh),
        .din      (shunt_code),
        .log2n    (log2n),
        .dout     (avg_sh)
    );

    pmon_avg #(
        .W  (16),
        .NW (10)
    ) u_avg_bus (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clr      (acc_clr),
        .add      (add_bus),
        .din      (bus_pos),
        .log2n    (log2n),
        .dout     (avg_bus)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_comb begin
        cfg_nxt   = cfg_r;
        cal_nxt   = cal_r;
        shunt_nxt = shunt_r;
        bus_nxt   = bus_r;
        cur_nxt   = cur_r;
        pwr_nxt   = pwr_r;
        ovf_nxt   = ovf_r;
        flag_nxt  = flag_r;
        rdata_nxt = rdata_r;
        srst_nxt  = 1'b0;
        if (reg_wr && reg_addr == `PMON_OFS_CAL) begin
            cal_nxt = reg_wdata & `PMON_CAL_MASK;
        end
        if (cfg_wr) begin
            srst_nxt = reg_wdata[`PMON_CFG_SRST];
            cfg_nxt  = reg_wdata;
            cfg_nxt[`PMON_CFG_SRST] = 1'b0;
            if (reg_wdata[`PMON_CFG_MODE +: 2] != 2'b00) begin
                flag_nxt = 1'b0;
            end
        end
        if (flag_clr) begin
            flag_nxt = 1'b0;
        end
        if (state_r == pmon_pkg::ST_MATH && !cfg_wr) begin
            shunt_nxt = sh_v;
            bus_nxt   = bus_v;
            cur_nxt   = cur_c;
            pwr_nxt   = pw_c[15:0];
            ovf_nxt   = sat_c;
            flag_nxt  = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                `PMON_OFS_CFG:   rdata_nxt = cfg_r;
                `PMON_OFS_SHUNT: rdata_nxt = shunt_r;
                `PMON_OFS_BUS:   rdata_nxt = bus_r;
                `PMON_OFS_PWR:   rdata_nxt = pwr_r;
                `PMON_OFS_CUR:   rdata_nxt = cur_r;
                `PMON_OFS_CAL:   rdata_nxt = cal_r;
                default:         rdata_nxt = 16'h0000;
            endcase
        end
        if (srst_r) begin
            // self reset acts like power-on, except that the read data in rdata_r keeps its value
            cfg_nxt   = `PMON_CFG_RST_VAL;
            cal_nxt   = `PMON_RES_RST_VAL;
            shunt_nxt = `PMON_RES_RST_VAL;
            bus_nxt   = `PMON_RES_RST_VAL;
            cur_nxt   = `PMON_RES_RST_VAL;
            pwr_nxt   = `PMON_RES_RST_VAL;
            ovf_nxt   = 1'b0;
            flag_nxt  = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= pmon_pkg::ST_IDLE;
            cfg_r   <= `PMON_CFG_RST_VAL;
            cal_r   <= `PMON_RES_RST_VAL;
            shunt_r <= `PMON_RES_RST_VAL;
            bus_r   <= `PMON_RES_RST_VAL;
            cur_r   <= `PMON_RES_RST_VAL;
            pwr_r   <= `PMON_RES_RST_VAL;
            rdata_r <= 16'h0000;
            scnt_r  <= '0;
            flag_r  <= 1'b0;
            ovf_r   <= 1'b0;
            busy_r  <= 1'b0;
            srst_r  <= 1'b0;
            trig_r  <= 1'b0;
        end else begin
            state_r <= srst_r ? pmon_pkg::ST_IDLE : state_nxt;
            cfg_r   <= cfg_nxt;
            cal_r   <= cal_nxt;
            shunt_r <= shunt_nxt;
            bus_r   <= bus_nxt;
            cur_r   <= cur_nxt;
            pwr_r   <= pwr_nxt;
            rdata_r <= rdata_nxt;
            scnt_r  <= scnt_nxt;
            flag_r  <= flag_nxt;
            ovf_r   <= ovf_nxt;
            busy_r  <= busy_nxt && !srst_r;
            srst_r  <= srst_nxt;
            trig_r  <= trig_nxt && !srst_r;
        end
    end

    assign reg_rdata            = rdata_r;
    assign conversion_done_flag = flag_r;
    assign math_ovf             = ovf_r;
    assign conv_busy            = busy_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_math;
        state_r == pmon_pkg::ST_MATH && !cfg_wr && !srst_r;
    endsequence
    sequence s_trig_idle;
        state_r == pmon_pkg::ST_IDLE && !cont && !cfg_wr;
    endsequence

    property p_rst_mode;
        $rose(rst_n) |-> cfg_r == `PMON_CFG_RST_VAL && mode == 3'h7;
    endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("mode not continuous after reset");

    property p_bus_msb;
        !bus_r[15];
    endproperty
    a_bus_msb: assert property (p_bus_msb)
        else $error("bus result bit 15 set");

    property p_cal_msb;
        reg_wr && reg_addr == `PMON_OFS_CAL && !srst_r
            |=> cal_r == {1'b0, $past(reg_wdata[14:0])};
    endproperty
    a_cal_msb: assert property (p_cal_msb)
        else $error("calibration write not kept as 15 bits");

    property p_abort;
        cfg_wr |=> state_r == pmon_pkg::ST_IDLE && !conv_busy;
    endproperty
    a_abort: assert property (p_abort)
        else $error("config write did not abort conversion");

    property p_flag_set;
        s_math |=> conversion_done_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("ready flag not set after products");

    property p_flag_cause;
        $rose(conversion_done_flag) |-> $past(state_r == pmon_pkg::ST_MATH);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("ready flag set before products done");

    property p_res_hold;
        $changed(shunt_r) || $changed(cur_r)
            |-> $past(state_r == pmon_pkg::ST_MATH) || $past(srst_r);
    endproperty
    a_res_hold: assert property (p_res_hold)
        else $error("result changed outside result update");

    property p_rd_shunt;
        reg_rd && reg_addr == `PMON_OFS_SHUNT |=> reg_rdata == $past(shunt_r);
    endproperty
    a_rd_shunt: assert property (p_rd_shunt)
        else $error("shunt result read wrong");

    property p_pdown;
        state_r == pmon_pkg::ST_IDLE && pdown && !cfg_wr
            |=> state_r == pmon_pkg::ST_IDLE;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("conversion started in power-down");

    property p_trig_once;
        s_math ##1 s_trig_idle |=> state_r == pmon_pkg::ST_IDLE;
    endproperty
    a_trig_once: assert property (p_trig_once)
        else $error("triggered mode ran a second set");

    property p_cur_val;
        s_math |=> cur_r == $past(cur_c) && pwr_r == $past(pw_c[15:0]);
    endproperty
    a_cur_val: assert property (p_cur_val)
        else $error("current or power result not stored");

endmodule : pmon_top
`default_nettype wire

/* pmon_defines.svh */
// Purpose: constants of the power monitor measurement and result block
// Assumes: 100 MHz core_clk, 10 ns period
// Notes:   offsets are register indices on the internal register port
//
// Summary of operation
// - config bits 5:3 pick shunt conversion time, 140 us up to 8.244 ms.
// - mode bits 2:0: 000/100 power-down, 001-011 triggered, 101-111 continuous.
// - after reset the mode is continuous shunt and bus.
// - latest shunt result, two's complement, read-only at 01h.
// - shunt result count is 2.5 uV, 7fff is 81.92 mV.
// - with averaging on, every result shows the averaged value.
// - latest bus result at 02h, overwritten when each averaged set of conversions finishes.
// - bus result count is 1.25 mV, 7fff is 40.96 V.
// - bit 15 of the bus result always reads zero.
// - power result is current times bus result, read-only at 03h.
// - power count equals 25 current steps.
// - current result is shunt result times calibration over 2048, read-only at 04h.
// - host writes 15-bit calibration at 05h, bit 15 unused.
// - config write aborts and restarts conversion; reads disturb nothing.
// - ready flag sets only after conversions, averaging and products finish.
// - config bits 11:9 pick 1,4,16,64,128,256,512 or 1024 samples.
`ifndef PMON_DEFINES_SVH
`define PMON_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMON_OFS_CFG     8'h00
`define PMON_OFS_SHUNT   8'h01
`define PMON_OFS_BUS     8'h02
`define PMON_OFS_PWR     8'h03
`define PMON_OFS_CUR     8'h04
`define PMON_OFS_CAL     8'h05

// ----------------------------------------
// config fields and reset values
// ----------------------------------------
`define PMON_CFG_SRST    15
`define PMON_CFG_AVG     9
`define PMON_CFG_BCT     6
`define PMON_CFG_SCT     3
`define PMON_CFG_MODE    0
`define PMON_CFG_RST_VAL 16'h4127
`define PMON_CAL_MASK    16'h7fff
`define PMON_RES_RST_VAL 16'h0000

// ----------------------------------------
// timing and scaling
// ----------------------------------------
`define PMON_CLK_NS      10
`define PMON_CT0_NS      140000
`define PMON_CT1_NS      204000
`define PMON_CT2_NS      332000
`define PMON_CT3_NS      588000
`define PMON_CT4_NS      1100000
`define PMON_CT5_NS      2116000
`define PMON_CT6_NS      4156000
`define PMON_CT7_NS      8244000
`define PMON_CUR_SHIFT   11
`define PMON_PWR_DIV     20000

`endif

/* pmon_pkg.sv */
// Purpose: types of the power monitor block
// Assumes: nothing
// Notes:   one-hot sequencer codes
package pmon_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHUNT = 4'b0010,
        ST_BUS   = 4'b0100,
        ST_MATH  = 4'b1000
    } pmon_state_e;

endpackage : pmon_pkg

/* pmon_conv_timer.sv */
// Purpose: conversion time counter per measured channel
// Assumes: start and abort are one-cycle pulses
// Notes:   done is a pulse exactly CT_CYC[code] cycles after start
`timescale 1ns/1ns
`default_nettype none
module pmon_conv_timer #(
    parameter int unsigned CT_CYC [8] = '{1, 1, 1, 1, 1, 1, 1, 1}
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [2:0] code,
    output logic            done
);
    localparam int CW = 20;

    for (genvar i = 0; i < 8; i++) begin : g_chk
        if (CT_CYC[i] == 0 || CT_CYC[i] >= (1 << CW)) begin : g_bad
            $error("conversion cycle count out of range");
        end
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          run_r;
    logic          run_nxt;

    assign done = run_r && (cnt_r == '0);

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (abort) begin
            run_nxt = 1'b0;
        end else if (start) begin
            cnt_nxt = CW'(CT_CYC[code] - 1);
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (cnt_r == '0) begin
                run_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ct_load;
        start && !abort |=> cnt_r == CW'(CT_CYC[$past(code)] - 1) && run_r;
    endproperty
    a_ct_load: assert property (p_ct_load)
        else $error("conversion time not loaded from code");

endmodule : pmon_conv_timer
`default_nettype wire

/* pmon_avg.sv */
// Purpose: sample accumulator that yields the mean of 2**log2n samples
// Assumes: caller adds exactly 2**log2n samples after clr
// Notes:   power-of-two counts let a shift stand in for a divider
`timescale 1ns/1ns
`default_nettype none
module pmon_avg #(
    parameter int W  = 16,
    parameter int NW = 10
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // samples
    input  wire logic                clr,
    input  wire logic                add,
    input  wire logic signed [W-1:0] din,
    input  wire logic [3:0]          log2n,
    output logic signed [W-1:0]      dout
);
    if (W < 2 || NW < 1 || NW > 15) begin : g_bad
        $error("accumulator widths out of range");
    end

    logic signed [W+NW-1:0] acc_r;
    logic signed [W+NW-1:0] acc_nxt;

    assign dout = W'(acc_r >>> log2n);

    always_comb begin
        acc_nxt = acc_r;
        if (clr) begin
            acc_nxt = '0;
        end else if (add) begin
            acc_nxt = acc_r + (W+NW)'(din);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_acc_sum;
        add && !clr |=> acc_r == $past(acc_r) + (W+NW)'($past(din));
    endproperty
    a_acc_sum: assert property (p_acc_sum)
        else $error("sample not added to accumulator");

endmodule : pmon_avg
`default_nettype wire

/* pmon_adc_model.sv */
// Purpose: front end stand-in feeding converter codes
// Assumes: levels settle well before a conversion ends
// Notes:   no noise modelled; raw bit 15 passed on
`timescale 1ns/1ns
`default_nettype none
module pmon_adc_model (
    // levels from the bench
    input  wire logic [15:0] shunt_lvl,
    input  wire logic [15:0] bus_lvl,
    // converter codes
    output logic      [15:0] shunt_code,
    output logic      [15:0] bus_code
);
    assign shunt_code = shunt_lvl;
    // bit 15 left as driven, the block must drop it
    assign bus_code   = bus_lvl;
endmodule : pmon_adc_model
`default_nettype wire

/* pmon_top_tb_top.sv */
// Purpose: self-checking bench of the power monitor result registers
// Assumes: shortened conversion times
// Notes:   read data checked against a queue of expectations
`timescale 1ns/1ns
`default_nettype none
`include "pmon_defines.svh"
module pmon_top_tb_top;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] shunt_lvl = 16'h0000;
    logic [15:0] bus_lvl   = 16'h0000;
    logic        flag_clr  = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] shunt_code;
    logic [15:0] bus_code;
    logic        conversion_done_flag;
    logic        math_ovf;
    logic        conv_busy;
    logic [15:0] expq[$];
    logic [31:0] seed      = 32'd87788;
    int          n_mismatch = 0;
    int          checked    = 0;

    always #5 core_clk = ~core_clk;

    localparam int unsigned CT [8] = '{5, 6, 7, 8, 9, 10, 11, 12};

    pmon_top #(.CT_CYC(CT)) u_pmon_top (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .shunt_code(shunt_code),
        .bus_code(bus_code), .flag_clr(flag_clr),
        .conversion_done_flag(conversion_done_flag),
        .math_ovf(math_ovf), .conv_busy(conv_busy));
    pmon_adc_model u_pmon_adc_model (.shunt_lvl(shunt_lvl),
        .bus_lvl(bus_lvl), .shunt_code(shunt_code), .bus_code(bus_code));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        expq.push_back(e);
        @(negedge core_clk);
        reg_rd = 1'b0;
    endtask : rd
    task automatic wait_done(output int n);
        n = 0;
        while (conversion_done_flag !== 1'b1 && n < 500) begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0, conversion_done_flag}, 16'h0001);
        chk({15'h0, conv_busy}, 16'h0000);
    endtask : wait_done
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // read data lands one cycle after the strobe
    always @(posedge core_clk) begin
        if (reg_rd === 1'b1) begin
            @(negedge core_clk);
            chk(reg_rdata, expq.pop_front());
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [15:0] sh;
        logic [15:0] bs;
        int          m;
        int          pw;
        int          n;
        logic [2:0]  c;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        rd(`PMON_OFS_CFG, 16'h4127);
        for (int a = 1; a < 6; a++) rd(a[7:0], 16'h0000);
        wr(`PMON_OFS_CAL, 16'hffff);
        rd(`PMON_OFS_CAL, 16'h7fff);
        wr(`PMON_OFS_SHUNT, 16'h1234);
        rd(`PMON_OFS_SHUNT, 16'h0000);
        rd(8'h10, 16'h0000);
        // unity gain keeps current equal to shunt, no saturation
        wr(`PMON_OFS_CAL, 16'h0800);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            sh = seed[15:0];
            bs = seed[31:16];
            shunt_lvl = sh;
            bus_lvl = bs;
            wr(`PMON_OFS_CFG, 16'h0323);
            wait_done(n);
            chk(16'(n), 16'(4 * (CT[4] + CT[4]) + 2));
            chk({15'h0, math_ovf}, 16'h0000);
            m = $signed(sh);
            if (m < 0) m = -m;
            pw = m * int'(bs & 16'h7fff) / 20000;
            rd(`PMON_OFS_SHUNT, sh);
            rd(`PMON_OFS_BUS, bs & 16'h7fff);
            rd(`PMON_OFS_CUR, sh);
            rd(`PMON_OFS_PWR, pw[15:0]);
        end
        flag_clr = 1'b1;
        @(negedge core_clk);
        flag_clr = 1'b0;
        repeat (100) @(negedge core_clk);
        chk({15'h0, conversion_done_flag}, 16'h0000);
        shunt_lvl = ~sh;
        // both power-down codes must leave the results alone
        for (int p = 0; p < 5; p += 4) begin
            wr(`PMON_OFS_CFG, 16'h0320 | 16'(p));
            repeat (60) @(negedge core_clk);
            rd(`PMON_OFS_SHUNT, sh);
        end
        bus_lvl = ~bs;
        seed = xs(seed);
        c = seed[2:0];
        wr(`PMON_OFS_CFG, {7'h01, 3'h4, c, 3'h5});
        wait_done(n);
        chk(16'(n), 16'(4 * CT[c] + 2));
        rd(`PMON_OFS_BUS, bs & 16'h7fff);
        rd(`PMON_OFS_SHUNT, ~sh);
        // triggered bus only: shunt result must stay
        c = seed[5:3];
        wr(`PMON_OFS_CFG, {7'h00, c, 3'h0, 3'h2});
        wait_done(n);
        chk(16'(n), 16'(CT[c] + 2));
        rd(`PMON_OFS_BUS, ~bs & 16'h7fff);
        rd(`PMON_OFS_SHUNT, ~sh);
        wr(`PMON_OFS_CFG, 16'h8000);
        repeat (2) @(negedge core_clk);
        rd(`PMON_OFS_CFG, 16'h4127);
        rd(`PMON_OFS_CAL, 16'h0000);
        repeat (2) @(negedge core_clk);
        conclude();
    end
endmodule : pmon_top_tb_top
`default_nettype wire
